// file: hw/urh_defs.vh
// urh_defs.vh: offsets, field positions and reset values of the root hub register bank
// assumes a byte-addressed plain register port, one 32-bit word per register
`ifndef URH_DEFS_VH
`define URH_DEFS_VH
`define URH_ADDR_W 8
`define URH_OFF_DESC_A 8'h48
`define URH_OFF_DESC_B 8'h4c
`define URH_OFF_STATUS 8'h50
`define URH_OFF_PORT1 8'h54
`define URH_OFF_PORT2 8'h58
`define URH_OFF_PORT3 8'h5c
`define URH_DESC_A_RST 32'h01001102
`define URH_DESC_B_RST 32'h00000000
`define URH_STATUS_RST 32'h00000000
`define URH_NPORTS_MAX 3
`define URH_CNT_LSB 0
`define URH_CNT_ONE 8'h01
`define URH_CNT_TWO 8'h02
`define URH_CNT_THREE 8'h03
`define URH_POTPGT_LSB 24
`define URH_NOCP_BIT 12
`define URH_OCPM_BIT 11
`define URH_MASK_MSB 31
`define URH_NRMAP_MSB 15
`define URH_PORT_STRIDE 8'h04
`define URH_POWER_SWITCH_MODE_SEL_BIT 8
`define URH_ALWAYS_POWERED_SEL_BIT 9
`define URH_MASK_LSB 16
`define URH_NRMAP_LSB 0
`define URH_ST_LPS_BIT 0
`define URH_ST_OCI_BIT 1
`define URH_ST_DRWE_BIT 15
`define URH_ST_LPSC_BIT 16
`define URH_ST_OCIC_BIT 17
`define URH_ST_CRWE_BIT 31
`define URH_PORT_PWR_BIT 8
`define URH_PORT_CLRPWR_BIT 0
`endif

// file: hw/urh_regs.v
// urh_regs.v: root hub descriptor and status register bank with port power control
// assumes a one-cycle register port, whole-word accesses, inputs synchronous to CLK_I
//
// How it works
// (RULE_01) mode selector ignored while always-powered set
// (RULE_02) mode 0 ganged, mode 1 per port
// (RULE_03) masked port obeys only per-port commands
// (RULE_04) unmasked port obeys only global commands
// (RULE_05) port count in descriptor bits 7-0
// (RULE_06) absent port status registers read zero
// (RULE_07) driver programs descriptor B at init
// (RULE_08) power mask in bits 31-16
// (RULE_09) mask disregarded in global mode
// (RULE_10) global power switching supported
// (RULE_11) non-removable map in bits 15-0
// (RULE_12) status low half, changes high half
// (RULE_13) driver writes zero to reserved bits
// (RULE_14) registers accessed as whole words
// (RULE_15) reserved bit 0 reads zero, ignores writes
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`include "urh_defs.vh"

module urh_regs (
	// clock and reset
	input wire CLK_I,
	input wire SRST_I,
	// configuration strap: low selects count 01h, high lets CFG_TWO_PORT_I choose
	input wire CFG_ONE_PORT_N_I,
	input wire CFG_TWO_PORT_I,
	// root hub inputs
	input wire OVERCURRENT_I,
	// register port
	input wire [7:0] ADDR_I,
	input wire [31:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	output reg [31:0] RDATA_O,
	// port power outputs, bit n for port n
	output reg [3:1] PORT_POWER_O
);

	// reset images of the three words and of their fields
	localparam [31:0] DESC_A_RST = `URH_DESC_A_RST;
	localparam [31:0] DESC_B_RST = `URH_DESC_B_RST;
	localparam [31:0] STATUS_RST = `URH_STATUS_RST;
	localparam [7:0] POTPGT_RST = DESC_A_RST[`URH_POTPGT_LSB + 7:`URH_POTPGT_LSB];
	localparam [7:0] CNT_RST = DESC_A_RST[`URH_CNT_LSB + 7:`URH_CNT_LSB];
	localparam [15:1] MASK_RST = DESC_B_RST[`URH_MASK_MSB:`URH_MASK_LSB + 1];
	localparam [15:1] NRMAP_RST = DESC_B_RST[`URH_NRMAP_MSB:`URH_NRMAP_LSB + 1];

	reg [7:0] potpgt_q;
	reg [7:0] potpgt_d;
	reg nocp_q;
	reg nocp_d;
	reg ocpm_q;
	reg ocpm_d;
	reg always_powered_sel_q;
	reg always_powered_sel_d;
	reg power_switch_mode_sel_q;
	reg power_switch_mode_sel_d;
	reg [7:0] port_count_field_q;
	reg [7:0] port_count_field_d;
	reg [15:1] port_power_mask_q;
	reg [15:1] port_power_mask_d;
	reg [15:1] nonremovable_map_q;
	reg [15:1] nonremovable_map_d;
	reg drwe_q;
	reg drwe_d;
	reg oci_q;
	reg oci_d;
	reg ocic_q;
	reg ocic_d;
	reg [3:1] pwr_q;
	reg [31:0] rdata_d;
	reg [31:0] rdata_out_d;
	wire [3:1] pwr_d;

	wire sel_a;
	wire sel_b;
	wire sel_s;
	wire wr_a;
	wire wr_b;
	wire wr_s;
	wire glob_set;
	wire glob_clr;
	wire drwe_set;
	wire drwe_clr;
	wire ocic_clr;
	wire ap_now;
	wire per_port_mode;

	// register decode and status command strobes
	assign sel_a = (ADDR_I == `URH_OFF_DESC_A);
	assign sel_b = (ADDR_I == `URH_OFF_DESC_B);
	assign sel_s = (ADDR_I == `URH_OFF_STATUS);
	assign wr_a = WR_I && sel_a;
	assign wr_b = WR_I && sel_b;
	assign wr_s = WR_I && sel_s;
	assign glob_set = wr_s && WDATA_I[`URH_ST_LPSC_BIT];
	assign glob_clr = wr_s && WDATA_I[`URH_ST_LPS_BIT];
	assign drwe_set = wr_s && WDATA_I[`URH_ST_DRWE_BIT];
	assign drwe_clr = wr_s && WDATA_I[`URH_ST_CRWE_BIT];
	assign ocic_clr = wr_s && WDATA_I[`URH_ST_OCIC_BIT];
	// always-powered takes hold with the write that sets it
	assign ap_now = wr_a ? WDATA_I[`URH_ALWAYS_POWERED_SEL_BIT] : always_powered_sel_q; // RULE_01
	assign per_port_mode = !always_powered_sel_q && power_switch_mode_sel_q; // RULE_01

	// port count follows the configuration straps
	always @* begin
		if (!CFG_ONE_PORT_N_I) begin
			port_count_field_d = `URH_CNT_ONE; // RULE_05
		end else if (CFG_TWO_PORT_I) begin
			port_count_field_d = `URH_CNT_TWO;
		end else begin
			port_count_field_d = `URH_CNT_THREE;
		end
	end

	// per-port power state: each port picks global or its own commands
	genvar g;
	generate
		for (g = 1; g <= `URH_NPORTS_MAX; g = g + 1) begin : g_port
			localparam [31:0] PADDR_W = `URH_OFF_PORT1 + `URH_PORT_STRIDE * (g - 1);
			wire pwr_wr;
			wire own;
			wire p_set;
			wire p_clr;
			assign pwr_wr = WR_I && (ADDR_I == PADDR_W[7:0]);
			assign own = per_port_mode && port_power_mask_q[g]; // RULE_03 RULE_09
			assign p_set = own ? (pwr_wr && WDATA_I[`URH_PORT_PWR_BIT]) : glob_set; // RULE_03 RULE_04
			assign p_clr = own ? (pwr_wr && WDATA_I[`URH_PORT_CLRPWR_BIT]) : glob_clr; // RULE_02
			// set beats clear when one write carries both
			assign pwr_d[g] = ap_now ? 1'b1 : (p_set ? 1'b1 : (p_clr ? 1'b0 : pwr_q[g])); // RULE_10
		end
	endgenerate

	// descriptor A writable fields
	always @* begin
		potpgt_d = potpgt_q;
		nocp_d = nocp_q;
		ocpm_d = ocpm_q;
		always_powered_sel_d = always_powered_sel_q;
		power_switch_mode_sel_d = power_switch_mode_sel_q;
		if (wr_a) begin
			potpgt_d = WDATA_I[`URH_POTPGT_LSB + 7:`URH_POTPGT_LSB];
			nocp_d = WDATA_I[`URH_NOCP_BIT];
			ocpm_d = WDATA_I[`URH_OCPM_BIT];
			always_powered_sel_d = WDATA_I[`URH_ALWAYS_POWERED_SEL_BIT];
			power_switch_mode_sel_d = WDATA_I[`URH_POWER_SWITCH_MODE_SEL_BIT];
		end
	end

	// descriptor B; bit 0 of each half is never stored
	always @* begin
		port_power_mask_d = port_power_mask_q;
		nonremovable_map_d = nonremovable_map_q;
		if (wr_b) begin
			port_power_mask_d = WDATA_I[`URH_MASK_MSB:`URH_MASK_LSB + 1]; // RULE_08 RULE_15
			nonremovable_map_d = WDATA_I[`URH_NRMAP_MSB:`URH_NRMAP_LSB + 1]; // RULE_11 RULE_15
		end
	end

	// remote wakeup enable: clear wins over set
	always @* begin
		drwe_d = drwe_q;
		if (drwe_clr) begin
			drwe_d = 1'b0;
		end else if (drwe_set) begin
			drwe_d = 1'b1;
		end
	end

	// over-current indicator and its change flag; hardware set beats the clear
	always @* begin
		oci_d = OVERCURRENT_I && !nocp_q && !ocpm_q;
		ocic_d = ocic_q;
		if (oci_q != oci_d) begin
			ocic_d = 1'b1;
		end else if (ocic_clr) begin
			ocic_d = 1'b0;
		end
	end

	// read data stands one cycle, zero otherwise
	always @* begin
		rdata_out_d = 32'h00000000;
		if (RD_I) begin
			rdata_out_d = rdata_d;
		end
	end

	always @(posedge CLK_I) begin
		if (SRST_I) begin
			potpgt_q <= POTPGT_RST;
			nocp_q <= DESC_A_RST[`URH_NOCP_BIT];
			ocpm_q <= DESC_A_RST[`URH_OCPM_BIT];
			always_powered_sel_q <= DESC_A_RST[`URH_ALWAYS_POWERED_SEL_BIT];
			power_switch_mode_sel_q <= DESC_A_RST[`URH_POWER_SWITCH_MODE_SEL_BIT];
		end else begin
			potpgt_q <= potpgt_d;
			nocp_q <= nocp_d;
			ocpm_q <= ocpm_d;
			always_powered_sel_q <= always_powered_sel_d;
			power_switch_mode_sel_q <= power_switch_mode_sel_d;
		end
	end

	always @(posedge CLK_I) begin
		if (SRST_I) begin
			port_count_field_q <= CNT_RST;
		end else begin
			port_count_field_q <= port_count_field_d; // RULE_05
		end
	end

	always @(posedge CLK_I) begin
		if (SRST_I) begin
			port_power_mask_q <= MASK_RST;
		end else begin
			port_power_mask_q <= port_power_mask_d;
		end
	end

	always @(posedge CLK_I) begin
		if (SRST_I) begin
			nonremovable_map_q <= NRMAP_RST;
		end else begin
			nonremovable_map_q <= nonremovable_map_d;
		end
	end

	always @(posedge CLK_I) begin
		if (SRST_I) begin
			drwe_q <= STATUS_RST[`URH_ST_DRWE_BIT];
		end else begin
			drwe_q <= drwe_d;
		end
	end

	always @(posedge CLK_I) begin
		if (SRST_I) begin
			oci_q <= STATUS_RST[`URH_ST_OCI_BIT];
		end else begin
			oci_q <= oci_d;
		end
	end

	always @(posedge CLK_I) begin
		if (SRST_I) begin
			ocic_q <= STATUS_RST[`URH_ST_OCIC_BIT];
		end else begin
			ocic_q <= ocic_d;
		end
	end

	always @(posedge CLK_I) begin
		if (SRST_I) begin
			pwr_q <= 3'h0;
		end else begin
			pwr_q <= pwr_d;
		end
	end

	always @(posedge CLK_I) begin
		if (SRST_I) begin
			PORT_POWER_O <= 3'h0;
		end else begin
			PORT_POWER_O <= pwr_d;
		end
	end

	always @(posedge CLK_I) begin
		if (SRST_I) begin
			RDATA_O <= 32'h00000000;
		end else begin
			RDATA_O <= rdata_out_d;
		end
	end

	// read mux; whole words only
	always @* begin
		rdata_d = 32'h00000000; // RULE_14
		case (ADDR_I)
			`URH_OFF_DESC_A: begin
				rdata_d = {potpgt_q, 11'h000, nocp_q, ocpm_q, 1'b0,
					always_powered_sel_q, power_switch_mode_sel_q, port_count_field_q};
			end
			`URH_OFF_DESC_B: begin
				rdata_d = {port_power_mask_q, 1'b0, nonremovable_map_q, 1'b0}; // RULE_15
			end
			`URH_OFF_STATUS: begin
				rdata_d = {14'h0000, ocic_q, 1'b0, drwe_q, 13'h0000, oci_q, 1'b0}; // RULE_12
			end
			`URH_OFF_PORT1: begin
				rdata_d = {23'h000000, pwr_q[1], 8'h00};
			end
			`URH_OFF_PORT2: begin
				if (port_count_field_q >= `URH_CNT_TWO) begin
					rdata_d = {23'h000000, pwr_q[2], 8'h00}; // RULE_06
				end
			end
			`URH_OFF_PORT3: begin
				if (port_count_field_q >= `URH_CNT_THREE) begin
					rdata_d = {23'h000000, pwr_q[3], 8'h00}; // RULE_06
				end
			end
			default: begin
				rdata_d = 32'h00000000;
			end
		endcase
	end

endmodule // urh_regs

// file: bench/urh_regs_properties.sv
// urh_regs_properties.sv: port checker for the root hub register bank
// assumes binding to urh_regs, straps steady around reads
`timescale 1ns/10ps
module urh_regs_properties (
	input wire CLK_I, SRST_I, CFG_ONE_PORT_N_I, CFG_TWO_PORT_I, OVERCURRENT_I,
	input wire [7:0] ADDR_I,
	input wire [31:0] WDATA_I, RDATA_O,
	input wire WR_I, RD_I,
	input wire [3:1] PORT_POWER_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SRST_I);
	wire [7:0] cnt = !CFG_ONE_PORT_N_I ? 8'h01 : CFG_TWO_PORT_I ? 8'h02 : 8'h03;
	sequence s_rd(a); RD_I && ADDR_I == a; endsequence
	a_unmapped_zero:
	assert property (RD_I && (ADDR_I < 8'h48 || ADDR_I > 8'h5c || ADDR_I[1:0] != 2'h0)
		|=> RDATA_O == 32'h0) else $error("unmapped read");
	a_idle_zero:
	assert property (!RD_I |=> RDATA_O == 32'h0) else $error("idle data");
	a_port_count:
	assert property (s_rd(8'h48) |=> RDATA_O[7:0] == $past(cnt, 2)) else $error("count");
	a_absent_zero:
	assert property (RD_I && (ADDR_I == 8'h58 && !CFG_ONE_PORT_N_I || ADDR_I == 8'h5c
		&& cnt != 8'h03) |=> RDATA_O == 32'h0) else $error("absent port");
	a_mask_bit0:
	assert property (s_rd(8'h4c) |=> !RDATA_O[16] && !RDATA_O[0]) else $error("bit0");
	a_status_layout:
	assert property (s_rd(8'h50) |=> RDATA_O[31:18] == 14'h0 && RDATA_O[16] == 1'b0
		&& RDATA_O[14:2] == 13'h0 && !RDATA_O[0]) else $error("status layout");
	a_power_cmd_only:
	assert property (!WR_I |=> $stable(PORT_POWER_O)) else $error("power moved");
	a_port_power_read:
	assert property (s_rd(8'h54) |=> RDATA_O[8] == $past(PORT_POWER_O[1])) else $error("pp");
endmodule // urh_regs_properties
bind urh_regs urh_regs_properties urh_regs_properties_inst (.CLK_I(CLK_I), .SRST_I(SRST_I),
	.CFG_ONE_PORT_N_I(CFG_ONE_PORT_N_I), .CFG_TWO_PORT_I(CFG_TWO_PORT_I),
	.OVERCURRENT_I(OVERCURRENT_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O),
	.WR_I(WR_I), .RD_I(RD_I), .PORT_POWER_O(PORT_POWER_O));

// file: bench/urh_regs_bench.sv
// urh_regs_bench.sv: self-checking bench for the root hub register bank
// assumes urh_regs and its checker are compiled first
`timescale 1ns/10ps
module urh_regs_bench;
	reg clk = 0, rst = 1, c1n = 1, c2 = 0, wr = 0, rd = 0;
	reg [7:0] adr = 8'h0;
	reg [31:0] wd = 32'h0;
	wire [31:0] rdata;
	wire [3:1] pwr;
	integer miscompares = 0, checks = 0, i;
	urh_regs urh_regs_inst (.CLK_I(clk), .SRST_I(rst), .CFG_ONE_PORT_N_I(c1n),
		.CFG_TWO_PORT_I(c2), .OVERCURRENT_I(1'b0), .ADDR_I(adr), .WDATA_I(wd),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PORT_POWER_O(pwr));
	initial forever #2.5 clk = ~clk;
	task chk(input [31:0] s, input [31:0] e); begin
		checks = checks + 1;
		if (s !== e) begin
			miscompares = miscompares + 1;
			$display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
		end
	end endtask
	task wa(input [7:0] a, input [31:0] d); begin
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	end endtask
	task ra(input [7:0] a, input [31:0] e); begin
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	end endtask
	task pw(input [3:1] e); begin
		#1 chk({29'h0, pwr}, {29'h0, e});
	end endtask
	task results; begin
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	end endtask
	task t_status; begin
		ra(8'h4c, 32'h0);
		pw(3'h0);
		ra(8'h60, 32'h0);
		wa(8'h50, 32'h00008000);
		ra(8'h50, 32'h00008000);
		wa(8'h50, 32'h80000000);
		ra(8'h50, 32'h0);
		wa(8'h4c, 32'hffffffff);
		ra(8'h4c, 32'hfffefffe);
		$display("status done");
	end endtask
	task t_power; begin
		wa(8'h48, 32'h01001002);
		wa(8'h4c, 32'h000e0000);
		wa(8'h50, 32'h00010000);
		pw(3'h7);
		wa(8'h50, 32'h1);
		pw(3'h0);
		wa(8'h48, 32'h01001102);
		wa(8'h4c, 32'h00040000);
		wa(8'h50, 32'h00010000);
		pw(3'h5);
		wa(8'h58, 32'h100);
		pw(3'h7);
		wa(8'h54, 32'h1);
		pw(3'h7);
		wa(8'h50, 32'h1);
		pw(3'h2);
		wa(8'h58, 32'h1);
		pw(3'h0);
		wa(8'h48, 32'h01001302);
		pw(3'h7);
		$display("power done");
	end endtask
	task t_count; begin
		for (i = 0; i < 3; i = i + 1) begin
			@(posedge clk);
			c1n <= i > 0;
			c2 <= i == 1;
			ra(8'h48, 32'h01001301 + i);
			ra(8'h58, i > 0 ? 32'h100 : 32'h0);
			ra(8'h5c, i == 2 ? 32'h100 : 32'h0);
		end
		$display("count done");
	end endtask
	initial begin
		#20000;
		miscompares = miscompares + 1;
		results;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_status;
		t_power;
		t_count;
		results;
	end
endmodule // urh_regs_bench
